// ==== logic/acs_defines.svh ====
// Offsets, field positions, reset values and timing counts
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_AXI_AW        6
`define ACS_OFF_CTRL      6'h00
`define ACS_OFF_RES_HI    6'h04
`define ACS_OFF_RES_LO    6'h08
`define ACS_OFF_IRQ_STAT  6'h0c
`define ACS_OFF_IRQ_CLR   6'h10
`define ACS_OFF_IRQ_EN    6'h14
`define ACS_CTRL_RST      8'h00
`define ACS_BIT_BUSY      0
`define ACS_IRQ_RST       2'h0
`define ACS_IRQ_DONE      0
`define ACS_IRQ_ABORT     1
`define ACS_RESP_OKAY     2'h0
`define ACS_RESP_SLVERR   2'h2
`define ACS_RES_W         10
`define ACS_PRESCALE_MAX  4'hf
`define ACS_SAMPLE_TICKS  2'h3
`define ACS_BIT_TICKS     2'h3
`endif

// ==== logic/acs_pkg.sv ====
// Types shared by the converter control sequencer
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE    = 2'b00,
    ACS_SAMPLE  = 2'b01,
    ACS_CONVERT = 2'b10
  } acs_state_e;

  // Same layout as the control register, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] chan_sel;
    logic       diff_mode_sel;
    logic       mux_out_sel;
    logic       clk_div_sel;
    logic       conv_active;
  } acs_ctrl_s;

  typedef struct packed {
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic       neg_en;
    logic       mux_route_en;
    logic       in_from_pin;
    logic       path_en;
    logic       conv_clk_en;
    logic       sample_hold;
    logic [9:0] trial;
  } acs_afe_s;
endpackage : acs_pkg

// ==== logic/acs_sar.sv ====
// Prescaler and successive approximation sequencer
`timescale 1ns/100ps
`include "acs_defines.svh"
module acs_sar
  import acs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       div16,
  input  wire logic       cmp_sync,
  output logic            busy,
  output logic            done,
  output logic            sample_hold,
  output logic [9:0]      trial,
  output logic [9:0]      result
);
  function automatic logic [9:0] bit_mask(input logic [3:0] idx);
    bit_mask = 10'h001 << idx;
  endfunction : bit_mask

  acs_state_e state_reg, state_next;
  logic [3:0] div_reg;
  logic [1:0] tick_reg;
  logic [3:0] idx_reg;
  logic [9:0] trial_reg;
  logic       done_reg;

  wire logic       running  = (state_reg != ACS_IDLE);
  wire logic       tick     = !div16 || (div_reg == `ACS_PRESCALE_MAX);
  wire logic       smp_end  = tick && (tick_reg == `ACS_SAMPLE_TICKS);
  wire logic       bit_end  = tick && (tick_reg == `ACS_BIT_TICKS);
  wire logic       last_bit = (idx_reg == 4'h0);
  wire logic [9:0] kept     = cmp_sync ? trial_reg
                                       : trial_reg & ~bit_mask(idx_reg);
  wire logic [3:0] idx_dec  = idx_reg - 4'h1;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ACS_IDLE:    if (start) state_next = ACS_SAMPLE;
      ACS_SAMPLE:  if (smp_end) state_next = ACS_CONVERT;
      ACS_CONVERT: if (bit_end && last_bit) state_next = ACS_IDLE;
      default:     state_next = ACS_IDLE;
    endcase
    if (abort) state_next = ACS_IDLE;
  end

  // Prescaler runs only during a conversion to save power
  always_ff @(posedge aclk) begin
    if (!aresetn || !running) div_reg <= 4'h0;
    else div_reg <= div_reg + 4'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ACS_IDLE;
      tick_reg  <= 2'h0;
      idx_reg   <= 4'h9;
      trial_reg <= 10'h000;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      done_reg  <= (state_reg == ACS_CONVERT) && bit_end && last_bit
                   && !abort;
      if (start && !running) begin
        tick_reg  <= 2'h0;
        idx_reg   <= 4'h9;
        trial_reg <= 10'h000;
      end else if (smp_end && state_reg == ACS_SAMPLE) begin
        tick_reg  <= 2'h0;
        trial_reg <= bit_mask(4'h9);
      end else if (bit_end && state_reg == ACS_CONVERT) begin
        tick_reg  <= 2'h0;
        idx_reg   <= idx_dec;
        trial_reg <= last_bit ? kept : kept | bit_mask(idx_dec);
      end else if (tick && running) begin
        tick_reg  <= tick_reg + 2'h1;
      end
    end
  end

  assign busy        = running;
  assign done        = done_reg;
  assign sample_hold = (state_reg == ACS_SAMPLE);
  assign trial       = trial_reg;
  assign result      = trial_reg;
endmodule : acs_sar

// ==== logic/acs_top.sv ====
// Converter control sequencer with AXI4-Lite register slave
//
// Function
// - Ten-bit results from a successive approximation core, sixteen inputs.
// - Single-ended start converts the one chosen channel, then stops.
// - Differential start converts the one chosen pair, then stops.
// - Software sees a control register and two result registers.
// - Reset clears control, powers converter down, results undefined.
// - Control bits: channel 7:4, mode 3, mux out 2, prescale 1, busy 0.
// - Writing busy one starts a conversion with current settings.
// - Completion clears busy; result registers valid from then.
// - Channel field picks positive input; mode and mux pick negative.
// - Mux output off: sixteen codes usable; on: fourteen channels (differential uses only codes 0 to 11).
// - Single-ended, mux off: code n selects channel n.
// - Differential, mux off: even code pairs up, odd code reverses.
// - Mux output and converter input can be routed to pins.
// - Mode zero is single-ended, mode one differential.
// - Busy low stops prescaler and converter clock.
// - Writing busy zero aborts; a one may follow immediately.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "acs_defines.svh"
module acs_top
  import acs_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`ACS_AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`ACS_AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    cmp_in,
  output acs_afe_s                     afe,
  output logic                         irq
);
  function automatic logic addr_known(
    input logic [`ACS_AXI_AW-1:0] a
  );
    addr_known = (a == `ACS_OFF_CTRL)     ||
                 (a == `ACS_OFF_RES_HI)   ||
                 (a == `ACS_OFF_RES_LO)   ||
                 (a == `ACS_OFF_IRQ_STAT) ||
                 (a == `ACS_OFF_IRQ_CLR)  ||
                 (a == `ACS_OFF_IRQ_EN);
  endfunction : addr_known

  // Write channel holding registers
  logic                   aw_hold_reg;
  logic [`ACS_AXI_AW-1:0] aw_addr_reg;
  logic                   w_hold_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;

  // Read channel
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;

  // Control, configuration and status
  acs_ctrl_s              ctrl_reg;
  acs_ctrl_s              cfg_reg;
  logic [9:0]             result_reg;
  logic [1:0]             irq_stat_reg;
  logic [1:0]             irq_stat_next;
  logic [1:0]             irq_en_reg;
  logic                   irq_reg;
  logic                   cmp_meta_reg;
  logic                   cmp_sync_reg;
  acs_afe_s               afe_reg;
  acs_afe_s               afe_next;

  // Converter core signals
  logic                   sar_busy;
  logic                   sar_done;
  logic                   sar_sample;
  logic [9:0]             sar_trial;
  logic [9:0]             sar_result;

  // Write decode
  wire logic do_write  = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire logic lane0     = w_strb_reg[0];
  wire logic wr_ctrl   = do_write && lane0 &&
                         (aw_addr_reg == `ACS_OFF_CTRL);
  wire logic wr_clr    = do_write && lane0 &&
                         (aw_addr_reg == `ACS_OFF_IRQ_CLR);
  wire logic wr_en     = do_write && lane0 &&
                         (aw_addr_reg == `ACS_OFF_IRQ_EN);
  wire logic wr_ok     = addr_known(aw_addr_reg);
  wire acs_ctrl_s wr_val = acs_ctrl_s'(w_data_reg[7:0]);

  // Busy bit drives start and abort
  wire logic start_req = wr_ctrl && wr_val.conv_active && !sar_busy;
  wire logic abort_req = wr_ctrl && !wr_val.conv_active && sar_busy;

  // Read decode
  wire logic rd_take   = s_axi_arvalid && !rvalid_reg;
  wire logic rd_ok     = addr_known(s_axi_araddr);
  wire acs_ctrl_s ctrl_view = '{
    chan_sel:      ctrl_reg.chan_sel,
    diff_mode_sel: ctrl_reg.diff_mode_sel,
    mux_out_sel:   ctrl_reg.mux_out_sel,
    clk_div_sel:   ctrl_reg.clk_div_sel,
    conv_active:   sar_busy
  };
  // Result packed right-justified: two bits high, eight bits low
  wire logic [31:0] rd_ctrl  = {24'h000000, ctrl_view};
  wire logic [31:0] rd_hi    = {30'h0, result_reg[9:8]};
  wire logic [31:0] rd_lo    = {24'h000000, result_reg[7:0]};
  wire logic [31:0] rd_stat  = {30'h0, irq_stat_reg};
  wire logic [31:0] rd_en    = {30'h0, irq_en_reg};
  wire logic [31:0] rd_mux   =
    (s_axi_araddr == `ACS_OFF_CTRL)     ? rd_ctrl :
    (s_axi_araddr == `ACS_OFF_RES_HI)   ? rd_hi   :
    (s_axi_araddr == `ACS_OFF_RES_LO)   ? rd_lo   :
    (s_axi_araddr == `ACS_OFF_IRQ_STAT) ? rd_stat :
    (s_axi_araddr == `ACS_OFF_IRQ_EN)   ? rd_en   :
                                          32'h00000000;

  // Settings in force: frozen while converting, live while idle
  wire acs_ctrl_s use_cfg = sar_busy ? cfg_reg : ctrl_reg;
  wire logic      use_mux = use_cfg.mux_out_sel;
  wire logic      use_dif = use_cfg.diff_mode_sel;
  wire logic [3:0] use_ch = use_cfg.chan_sel;

  // Channel decode: partner of a pair is the code with bit 0 flipped
  wire logic [3:0] pos_dec  = use_ch;
  wire logic [3:0] neg_dec  = {use_ch[3:1], ~use_ch[0]};
  // With mux out on, upper pins carry the mux and converter paths
  wire logic       ch_usable = !use_mux || (use_ch < 4'hc) ||
                               (!use_dif && use_ch < 4'he);

  always_comb begin
    afe_next              = afe_reg;
    afe_next.pos_sel      = pos_dec;
    afe_next.neg_sel      = (use_dif && ch_usable) ? neg_dec : 4'h0;
    afe_next.neg_en       = use_dif && ch_usable;
    afe_next.mux_route_en = use_mux;
    afe_next.in_from_pin  = use_mux;
    // Mux path settles ahead of a start when routed to pins
    afe_next.path_en      = (sar_busy || use_mux) && ch_usable;
    afe_next.conv_clk_en  = sar_busy;
    afe_next.sample_hold  = sar_sample;
    afe_next.trial        = sar_trial;
  end

  // Analog comparator arrives asynchronously
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_in;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `ACS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `ACS_RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      rdata_reg  <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control register; busy bit lives in the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= acs_ctrl_s'(`ACS_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_reg <= wr_val;
    end
  end

  // Settings captured at start so later writes cannot disturb it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= acs_ctrl_s'(`ACS_CTRL_RST);
    end else if (start_req) begin
      cfg_reg <= wr_val;
    end
  end

  // Result left without reset, as its contents are undefined
  always_ff @(posedge aclk) begin
    if (sar_done) begin
      result_reg <= sar_result;
    end
  end

  // Sticky events: a new event beats a clear in the same cycle
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_clr) begin
      irq_stat_next = irq_stat_next & ~w_data_reg[1:0];
    end
    if (sar_done) begin
      irq_stat_next[`ACS_IRQ_DONE] = 1'b1;
    end
    if (abort_req) begin
      irq_stat_next[`ACS_IRQ_ABORT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= `ACS_IRQ_RST;
      irq_en_reg   <= `ACS_IRQ_RST;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_next & (wr_en ? w_data_reg[1:0]
                                               : irq_en_reg));
      if (wr_en) begin
        irq_en_reg <= w_data_reg[1:0];
      end
    end
  end

  // Front end drive; reset leaves converter powered down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afe_reg <= '0;
    end else begin
      afe_reg <= afe_next;
    end
  end

  acs_sar u_sar (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (start_req),
    .abort       (abort_req),
    .div16       (cfg_reg.clk_div_sel),
    .cmp_sync    (cmp_sync_reg),
    .busy        (sar_busy),
    .done        (sar_done),
    .sample_hold (sar_sample),
    .trial       (sar_trial),
    .result      (sar_result)
  );

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready  = !w_hold_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign afe           = afe_reg;
  assign irq           = irq_reg;
endmodule : acs_top

// ==== tb/acs_properties.sv ====
// Port-level properties of the converter control sequencer
`timescale 1ns/100ps
module acs_properties
  import acs_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input acs_afe_s         afe,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_idle: assert property (disable iff (1'h0)
    !aresetn |=> (afe == '0 && !irq)) else $error("not idle after reset");
  a_route_pins: assert property (
    afe.mux_route_en == afe.in_from_pin) else $error("pin routing split");
  a_pair_swap: assert property (
    (afe.conv_clk_en && afe.neg_en && !afe.mux_route_en)
    |-> afe.neg_sel == (afe.pos_sel ^ 4'h1)) else $error("bad pair");
  a_single_neg: assert property (
    (afe.conv_clk_en && !afe.neg_en) |-> afe.neg_sel == 4'h0)
    else $error("single ended negative input set");
  a_all_usable: assert property (
    (afe.conv_clk_en && !afe.mux_route_en) |-> afe.path_en)
    else $error("path off during conversion");
  a_idle_hold: assert property (
    !afe.conv_clk_en |-> !afe.sample_hold) else $error("sampling idle");
  a_conv_ends: assert property (
    $rose(afe.conv_clk_en) |-> afe.trial == 10'h000
    ##[1:760] !afe.conv_clk_en) else $error("conversion runs on");
  a_write_resp: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
    |-> ##2 s_axi_bvalid) else $error("late write response");
  a_resp_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule : acs_properties

bind acs_top acs_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .afe, .irq);

// ==== tb/acs_afe_model.sv ====
// Comparator model of the analog front end
`timescale 1ns/100ps
module acs_afe_model
  import acs_pkg::*;
(
  input acs_afe_s   afe,
  output logic      cmp_in
);
  // Level encodes both channels, so the result exposes the routing
  wire logic [9:0] level = {afe.pos_sel,
                            afe.neg_en ? afe.neg_sel : 4'h0, 2'h2};
  // Pins stay high-impedance inputs, never driven by the model
  // A disabled path reads as no signal
  assign cmp_in = afe.path_en && (level >= afe.trial);
endmodule : acs_afe_model

// ==== tb/adc_control_sequencer_bench.sv ====
// Self-checking bench of the converter control sequencer
`timescale 1ns/100ps
module adc_control_sequencer_bench
  import acs_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, cmp_in, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d, h;
  acs_afe_s    afe;
  int          fail_count = 0, total_checks = 0, clk_cnt = 0, len;
  // {control write, expected result}
  logic [17:0] rows [7] = '{{8'h01, 10'h002}, {8'h51, 10'h142},
    {8'hf1, 10'h3c2}, {8'h09, 10'h006}, {8'h19, 10'h042},
    {8'hc9, 10'h336}, {8'hfb, 10'h3fa}};

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) if (afe.conv_clk_en === 1'h1) clk_cnt <= clk_cnt + 1;

  acs_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_in, .afe, .irq);
  acs_afe_model u_afe (.afe, .cmp_in);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  // Poll busy, then fetch both result halves into d
  task automatic finish_conv;
    do rd(6'h00); while (d[0] !== 1'h0);
    rd(6'h04);
    h = d;
    rd(6'h08);
    d = {22'h0, h[1:0], d[7:0]};
  endtask : finish_conv

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(6'h00);
    check(d, 32'h0);
    check({6'h0, afe, irq}, 32'h0);
    $display("reset test done");
    wr(6'h14, 32'h3);
    for (int i = 0; i < 7; i++) begin
      clk_cnt = 0;
      wr(6'h00, {24'h0, rows[i][17:10]});
      check(r, 2'h0);
      finish_conv();
      check(d, {22'h0, rows[i][9:0]});
      len = rows[i][11] ? 704 : 44;
      check(clk_cnt >= len && clk_cnt <= len + 20, 1'h1);
      rd(6'h00);
      check(d, {24'h0, rows[i][17:10] & 8'hfe});
    end
    $display("row tests done");
    check(irq, 1'h1);
    wr(6'h14, 32'h0);
    repeat (2) @(posedge aclk);
    check(irq, 1'h0);
    wr(6'h10, 32'h3);
    rd(6'h0c);
    check(d, 32'h0);
    wr(6'h14, 32'h3);
    $display("interrupt test done");
    // Abort a slow single-ended conversion, restart at once on a pair
    wr(6'h00, 32'h53);
    wr(6'h00, 32'h52);
    wr(6'h00, 32'h19);
    finish_conv();
    check(d, 32'h042);
    rd(6'h0c);
    check(d, 32'h3);
    check(irq, 1'h1);
    wr(6'h10, 32'h3);
    $display("restart test done");
    wr(6'h00, 32'h09);
    wr(6'h00, 32'hf1);
    finish_conv();
    check(d, 32'h006);
    rd(6'h00);
    check(d, 32'hf0);
    $display("field write test done");
    wr(6'h00, 32'h34);
    repeat (2) @(posedge aclk);
    check({afe.mux_route_en, afe.path_en}, 2'h3);
    wr(6'h00, 32'he4);
    repeat (2) @(posedge aclk);
    check(afe.path_en, 1'h0);
    wr(6'h00, 32'hc8);
    repeat (2) @(posedge aclk);
    check(afe.path_en, 1'h0);
    wr(6'h00, 32'h00);
    $display("mux output test done");
    // Write without byte lane 0 must leave control untouched
    s_axi_wstrb <= 4'h0;
    wr(6'h00, 32'h50);
    check(r, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(6'h00);
    check(d, 32'h0);
    $display("byte lane test done");
    wr(6'h18, 32'h1);
    check(r, 2'h2);
    rd(6'h18);
    check({r, d}, {2'h2, 32'h0});
    $display("unmapped test done");
    end_sim();
  end
endmodule : adc_control_sequencer_bench
